// file: hw/cod_pkg.sv
/*
  constants for the option word decoder: field positions, register offsets,
  reset values and timing counts.
  assumes a 100 MHz system clock and 15-bit option words.
*/
package cod_pkg;

  // ************************************************************
  // word layout
  // ************************************************************
  localparam int          WORD_W        = 15;
  localparam logic [14:0] WORD_RESET    = 15'h7fff;
  localparam int          W0_SRC_SEL    = 14;
  localparam int          W0_WARMUP     = 13;
  localparam int          W0_RST_MODE   = 10;
  localparam int          W0_LVR_HI     = 8;
  localparam int          W0_LVR_LO     = 7;
  localparam int          W0_PIN_SEL    = 6;
  localparam int          W0_WDT_N      = 5;
  localparam int          W0_FLT_WIDTH  = 4;
  localparam int          W0_FLT_EN     = 3;
  localparam int          W0_PROT_HI    = 2;
  localparam int          W1_SUB_OSC    = 13;
  localparam int          W1_TRIM_HI    = 12;
  localparam int          W1_TRIM_LO    = 7;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam logic [3:0]  OFS_WORD0     = 4'h0;
  localparam logic [3:0]  OFS_WORD1     = 4'h1;
  localparam logic [3:0]  OFS_LINK_A    = 4'h2;
  localparam logic [3:0]  OFS_LINK_B    = 4'h3;
  localparam logic [3:0]  OFS_LINK_C    = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h5;
  // linked register a: warm-up, reset mode, level code
  localparam int          LA_WARMUP     = 0;
  localparam int          LA_RST_MODE   = 1;
  localparam int          LA_LVR_LO     = 2;
  localparam int          LA_LVR_HI     = 3;
  // linked register b: pin select, watchdog, filter width, filter enable
  localparam int          LB_PIN_SEL    = 0;
  localparam int          LB_WDT_N      = 1;
  localparam int          LB_FLT_WIDTH  = 2;
  localparam int          LB_FLT_EN     = 3;
  // linked register c: trim and sub-oscillator select
  localparam int          LC_TRIM_HI    = 5;
  localparam int          LC_SUB_OSC    = 6;
  // status register
  localparam int          ST_LATCHED    = 0;
  localparam int          ST_LV_RESET   = 1;
  localparam int          ST_SRC_SEL    = 2;

  // ************************************************************
  // decoded values and timing
  // ************************************************************
  localparam logic [5:0]  WARMUP_LONG   = 6'h20;
  localparam logic [5:0]  WARMUP_SHORT  = 6'h08;
  localparam logic [5:0]  FLT_NARROW    = 6'h08;
  localparam logic [5:0]  FLT_WIDE      = 6'h20;
  localparam logic [5:0]  TRIM_NOMINAL  = 6'h3f;
  localparam logic [6:0]  TRIM_TOP      = 7'h3f;
  localparam logic [6:0]  TRIM_BASE     = 7'h20;
  localparam int          CLK_MHZ       = 100;
  localparam int          LV_HOLD_NS    = 5000;
  localparam int          LV_HOLD_CYC   = (LV_HOLD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic {COD_WAIT, COD_LATCHED} cod_phase_t;

endpackage

// file: hw/cod_lv_filter.sv
/*
  low-voltage persistence filter: raises a reset flag once the comparator
  has reported low supply for a full hold time, drops it on release.
  assumes comparator inputs already synchronous to i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cod_lv_filter #(
  parameter int HOLD_CYCLES = cod_pkg::LV_HOLD_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_below,
  input  wire logic i_release,
  output logic      o_reset
);

  localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

  if (HOLD_CYCLES < 1) begin : g_bad
    $error("cod_lv_filter: HOLD_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             flag;
  } cod_flt_t;

  cod_flt_t st;
  cod_flt_t next_st;

  // ************************************************************
  // hold counter
  // ************************************************************
  always_comb
  begin
    next_st = st;
    if (!i_enable) begin
      next_st = '0;
    end else if (i_below) begin
      if (st.count == CNT_W'(HOLD_CYCLES - 1)) begin
        next_st.flag = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end else begin
      next_st.count = '0;
      if (i_release) begin
        next_st.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_reset = st.flag;

endmodule // cod_lv_filter
`default_nettype wire

// file: hw/cod_option_decode.sv
/*
  option word decoder: latches the two nonvolatile option words at power-on,
  decodes them for clock, reset, watchdog and pin logic, and offers them and
  the linked control registers on a plain register port.
  assumes i_rst_n is the power-on reset and the option words are stable
  when it is released; all inputs are synchronous to i_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cod_option_decode #(
  parameter int LV_HOLD_CYCLES = cod_pkg::LV_HOLD_CYC
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // nonvolatile option words
  input  wire logic [cod_pkg::WORD_W-1:0] i_option_word0,
  input  wire logic [cod_pkg::WORD_W-1:0] i_option_word1,
  // register port
  input  wire logic [cod_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [cod_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [cod_pkg::DATA_W-1:0] o_rdata,
  // supply comparators
  input  wire logic                       i_vdd_below_2v7,
  input  wire logic                       i_vdd_above_2v9,
  input  wire logic                       i_vdd_below_3v0,
  input  wire logic                       i_vdd_above_3v2,
  // shared pin and operating mode
  input  wire logic                       i_shared_io_pin,
  input  wire logic                       i_mode_green,
  input  wire logic                       i_mode_idle,
  input  wire logic                       i_mode_sleep,
  // decoded values
  output logic                            o_options_valid,
  output logic      [5:0]                 o_warmup_clocks,
  output logic                            o_post_reset_green,
  output logic                            o_lv_reset_enable,
  output logic                            o_lv_level_3v0,
  output logic                            o_lv_reset,
  output logic                            o_ext_reset_pin_en,
  output logic                            o_ext_reset,
  output logic                            o_watchdog_enable,
  output logic                            o_filter_enable,
  output logic      [5:0]                 o_filter_min_width,
  output logic                            o_code_protect,
  output logic                            o_sub_osc_64k,
  output logic      [5:0]                 o_osc_trim,
  output logic      [6:0]                 o_trim_period_pct
);

  if (LV_HOLD_CYCLES < 1) begin : g_bad
    $error("cod_option_decode: LV_HOLD_CYCLES must be at least 1");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cod_pkg::cod_phase_t              phase;
    logic [cod_pkg::WORD_W-1:0]       word0;
    logic [cod_pkg::WORD_W-1:0]       word1;
    logic [3:0]                       link_a;
    logic [3:0]                       link_b;
    logic [6:0]                       link_c;
    logic [cod_pkg::DATA_W-1:0]       rdata;
    logic                             valid;
    logic [5:0]                       warmup;
    logic                             green;
    logic                             lv_en;
    logic                             lv_3v0;
    logic                             lv_reset;
    logic                             pin_en;
    logic                             ext_reset;
    logic                             wdt_en;
    logic                             flt_en;
    logic [5:0]                       flt_width;
    logic                             protect;
    logic                             sub_64k;
    logic [5:0]                       trim;
    logic [6:0]                       trim_pct;
  } cod_state_t;

  cod_state_t st;
  cod_state_t next_st;

  // effective settings after source selection
  logic       src_opt;
  logic       eff_warmup;
  logic       eff_mode;
  logic [1:0] eff_lvr;
  logic       eff_pin;
  logic       eff_wdt_n;
  logic       eff_width;
  logic       eff_flt;
  logic [5:0] eff_trim;
  logic       eff_sub;
  logic       lv_flag;
  logic       lv_below;
  logic       lv_release;

  // ************************************************************
  // source selection
  // ************************************************************
  always_comb
  begin
    src_opt = st.word0[cod_pkg::W0_SRC_SEL];
    if (src_opt) begin
      eff_warmup = st.word0[cod_pkg::W0_WARMUP];
      eff_mode   = st.word0[cod_pkg::W0_RST_MODE];
      eff_lvr    = st.word0[cod_pkg::W0_LVR_HI:cod_pkg::W0_LVR_LO];
      eff_pin    = st.word0[cod_pkg::W0_PIN_SEL];
      eff_wdt_n  = st.word0[cod_pkg::W0_WDT_N];
      eff_width  = st.word0[cod_pkg::W0_FLT_WIDTH];
      eff_flt    = st.word0[cod_pkg::W0_FLT_EN];
      eff_trim   = st.word1[cod_pkg::W1_TRIM_HI:cod_pkg::W1_TRIM_LO];
      eff_sub    = st.word1[cod_pkg::W1_SUB_OSC];
    end else begin
      eff_warmup = st.link_a[cod_pkg::LA_WARMUP];
      eff_mode   = st.link_a[cod_pkg::LA_RST_MODE];
      eff_lvr    = st.link_a[cod_pkg::LA_LVR_HI:cod_pkg::LA_LVR_LO];
      eff_pin    = st.link_b[cod_pkg::LB_PIN_SEL];
      eff_wdt_n  = st.link_b[cod_pkg::LB_WDT_N];
      eff_width  = st.link_b[cod_pkg::LB_FLT_WIDTH];
      eff_flt    = st.link_b[cod_pkg::LB_FLT_EN];
      eff_trim   = st.link_c[cod_pkg::LC_TRIM_HI:0];
      eff_sub    = st.link_c[cod_pkg::LC_SUB_OSC];
    end
    // level code 01 watches 2.7V, 00 watches 3.0V
    if (eff_lvr[0]) begin
      lv_below   = i_vdd_below_2v7;
      lv_release = i_vdd_above_2v9;
    end else begin
      lv_below   = i_vdd_below_3v0;
      lv_release = i_vdd_above_3v2;
    end
  end

  // ************************************************************
  // low-voltage persistence
  // ************************************************************
  cod_lv_filter #(
    .HOLD_CYCLES (LV_HOLD_CYCLES)
  ) u_lv_filter (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_enable  (st.valid && !eff_lvr[1]),
    .i_below   (lv_below),
    .i_release (lv_release),
    .o_reset   (lv_flag)
  );

  // ************************************************************
  // latch, registers and decode
  // ************************************************************
  always_comb
  begin
    next_st = st;
    next_st.rdata = '0;
    case (st.phase)
      cod_pkg::COD_WAIT:
      begin
        // capture once after power-on release, then never again
        next_st.word0 = i_option_word0;
        next_st.word1 = i_option_word1;
        next_st.link_a = {i_option_word0[cod_pkg::W0_LVR_HI:cod_pkg::W0_LVR_LO],
                          i_option_word0[cod_pkg::W0_RST_MODE],
                          i_option_word0[cod_pkg::W0_WARMUP]};
        next_st.link_b = {i_option_word0[cod_pkg::W0_FLT_EN],
                          i_option_word0[cod_pkg::W0_FLT_WIDTH],
                          i_option_word0[cod_pkg::W0_WDT_N],
                          i_option_word0[cod_pkg::W0_PIN_SEL]};
        next_st.link_c = {i_option_word1[cod_pkg::W1_SUB_OSC],
                          i_option_word1[cod_pkg::W1_TRIM_HI:cod_pkg::W1_TRIM_LO]};
        next_st.phase = cod_pkg::COD_LATCHED;
      end
      cod_pkg::COD_LATCHED:
      begin
        next_st.valid = 1'b1;
        // linked registers are writable only when sourced from registers
        if (i_wr && !src_opt) begin
          case (i_addr)
            cod_pkg::OFS_LINK_A: next_st.link_a = i_wdata[3:0];
            cod_pkg::OFS_LINK_B: next_st.link_b = i_wdata[3:0];
            cod_pkg::OFS_LINK_C: next_st.link_c = i_wdata[6:0];
            default:             next_st.link_a = st.link_a;
          endcase
        end
        next_st.warmup = eff_warmup ? cod_pkg::WARMUP_SHORT : cod_pkg::WARMUP_LONG;
        next_st.green = !eff_mode;
        next_st.lv_en = !eff_lvr[1];
        next_st.lv_3v0 = !eff_lvr[1] && !eff_lvr[0];
        next_st.lv_reset = lv_flag;
        next_st.pin_en = !eff_pin;
        next_st.ext_reset = !eff_pin && !i_shared_io_pin;
        next_st.wdt_en = !eff_wdt_n;
        next_st.flt_width = eff_width ? cod_pkg::FLT_WIDE : cod_pkg::FLT_NARROW;
        next_st.flt_en = eff_flt && !(i_mode_green || i_mode_idle || i_mode_sleep);
        next_st.protect = (st.word0[cod_pkg::W0_PROT_HI:0] == 3'h0);
        next_st.sub_64k = !eff_sub;
        next_st.trim = eff_trim;
        next_st.trim_pct = eff_trim[5] ? ({1'b0, eff_trim} - cod_pkg::TRIM_TOP)
                                       : (cod_pkg::TRIM_BASE - {1'b0, eff_trim});
      end
      default:
      begin
        next_st.phase = cod_pkg::COD_WAIT;
      end
    endcase
    // read data appear in the cycle after the strobe
    if (i_rd) begin
      case (i_addr)
        cod_pkg::OFS_WORD0:  next_st.rdata = {1'b0, st.word0};
        cod_pkg::OFS_WORD1:  next_st.rdata = {1'b0, st.word1};
        cod_pkg::OFS_LINK_A: next_st.rdata = {12'h0000, st.link_a};
        cod_pkg::OFS_LINK_B: next_st.rdata = {12'h0000, st.link_b};
        cod_pkg::OFS_LINK_C: next_st.rdata = {9'h000, st.link_c};
        cod_pkg::OFS_STATUS: next_st.rdata = {13'h0000, src_opt, st.lv_reset, st.valid};
        default:             next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) begin
      st           <= '0;
      st.phase     <= cod_pkg::COD_WAIT;
      st.word0     <= cod_pkg::WORD_RESET;
      st.word1     <= cod_pkg::WORD_RESET;
      st.link_a    <= 4'hf;
      st.link_b    <= 4'hf;
      st.link_c    <= 7'h7f;
      st.warmup    <= cod_pkg::WARMUP_SHORT;
      st.flt_width <= cod_pkg::FLT_WIDE;
      st.trim      <= cod_pkg::TRIM_NOMINAL;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_rdata            = st.rdata;
  assign o_options_valid    = st.valid;
  assign o_warmup_clocks    = st.warmup;
  assign o_post_reset_green = st.green;
  assign o_lv_reset_enable  = st.lv_en;
  assign o_lv_level_3v0     = st.lv_3v0;
  assign o_lv_reset         = st.lv_reset;
  assign o_ext_reset_pin_en = st.pin_en;
  assign o_ext_reset        = st.ext_reset;
  assign o_watchdog_enable  = st.wdt_en;
  assign o_filter_enable    = st.flt_en;
  assign o_filter_min_width = st.flt_width;
  assign o_code_protect     = st.protect;
  assign o_sub_osc_64k      = st.sub_64k;
  assign o_osc_trim         = st.trim;
  assign o_trim_period_pct  = st.trim_pct;

endmodule // cod_option_decode
`default_nettype wire

// file: sim/cod_option_decode_chk.sv
/*
  checker for the option word decoder: latch timing and decode relations.
  assumes it is bound onto cod_option_decode, one clock, async active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module cod_option_decode_chk #(
  parameter int LV_HOLD_CYCLES = cod_pkg::LV_HOLD_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [14:0] i_option_word0,
  input wire logic [14:0] i_option_word1,
  input wire logic        i_wr,
  input wire logic        i_vdd_below_2v7,
  input wire logic        i_vdd_below_3v0,
  input wire logic        i_shared_io_pin,
  input wire logic        i_mode_green,
  input wire logic        i_mode_idle,
  input wire logic        i_mode_sleep,
  input wire logic        o_options_valid,
  input wire logic [5:0]  o_warmup_clocks,
  input wire logic        o_post_reset_green,
  input wire logic        o_lv_reset_enable,
  input wire logic        o_lv_level_3v0,
  input wire logic        o_lv_reset,
  input wire logic        o_ext_reset_pin_en,
  input wire logic        o_ext_reset,
  input wire logic        o_watchdog_enable,
  input wire logic        o_filter_enable,
  input wire logic [5:0]  o_filter_min_width,
  input wire logic        o_code_protect,
  input wire logic        o_sub_osc_64k,
  input wire logic [5:0]  o_osc_trim,
  input wire logic [6:0]  o_trim_period_pct
);
  // ************************************************************
  // helpers
  // ************************************************************
  logic [6:0] exp_pct;
  logic       busy;
  logic       below_sel;
  assign exp_pct   = o_osc_trim[5] ? {1'b0, o_osc_trim} - 7'h3f : 7'h20 - {1'b0, o_osc_trim};
  assign busy      = i_mode_green | i_mode_idle | i_mode_sleep;
  assign below_sel = o_lv_level_3v0 ? i_vdd_below_3v0 : i_vdd_below_2v7;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ************************************************************
  // properties
  // ************************************************************
  property p_valid_time;
    $rose(o_options_valid) |-> $past(i_rst_n, 2) && !$past(i_rst_n, 3);
  endproperty
  a_valid_time: assert property (p_valid_time) else $error("valid rose at wrong edge");
  property p_init_clock;
    $rose(o_options_valid) |-> o_warmup_clocks == ($past(i_option_word0[13], 2) ? 6'h08 : 6'h20)
      && o_sub_osc_64k == !$past(i_option_word1[13], 2) && o_osc_trim == $past(i_option_word1[12:7], 2);
  endproperty
  a_init_clock: assert property (p_init_clock) else $error("clock options wrong");
  property p_init_reset;
    $rose(o_options_valid) |-> o_post_reset_green == !$past(i_option_word0[10], 2)
      && o_lv_reset_enable == !$past(i_option_word0[8], 2);
  endproperty
  a_init_reset: assert property (p_init_reset) else $error("reset options wrong");
  property p_init_pins;
    $rose(o_options_valid) |-> o_watchdog_enable == !$past(i_option_word0[5], 2)
      && o_filter_min_width == ($past(i_option_word0[4], 2) ? 6'h20 : 6'h08)
      && o_code_protect == ($past(i_option_word0[2:0], 2) == 3'b000);
  endproperty
  a_init_pins: assert property (p_init_pins) else $error("pin options wrong");
  property p_ext_reset;
    (!i_shared_io_pin && o_ext_reset_pin_en)[*3] |=> o_ext_reset;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("pin reset missing");
  property p_filter_off;
    busy[*2] |=> !o_filter_enable;
  endproperty
  a_filter_off: assert property (p_filter_off) else $error("filter on in low power mode");
  property p_lv;
    $rose(o_lv_reset) |-> o_lv_reset_enable && $past(below_sel, 2) && $past(below_sel, 3);
  endproperty
  a_lv: assert property (p_lv) else $error("low voltage reset without hold");
  property p_hold;
    $past(o_options_valid) && !$past(i_wr) && !$past(i_wr, 2) |-> $stable(o_warmup_clocks)
      && $stable(o_code_protect) && $stable(o_sub_osc_64k) && $stable(o_osc_trim);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded value changed");
  property p_pct;
    o_options_valid && $stable(o_osc_trim) |-> o_trim_period_pct == exp_pct;
  endproperty
  a_pct: assert property (p_pct) else $error("trim percent wrong");
  c_lv: cover property ($rose(o_lv_reset));
  c_ext: cover property ($rose(o_ext_reset));
  c_busy: cover property (busy ##1 !o_filter_enable);
endmodule // cod_option_decode_chk
bind cod_option_decode cod_option_decode_chk #(.LV_HOLD_CYCLES(LV_HOLD_CYCLES)) cod_option_decode_chk_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_option_word0(i_option_word0), .i_option_word1(i_option_word1),
  .i_wr(i_wr), .i_vdd_below_2v7(i_vdd_below_2v7), .i_vdd_below_3v0(i_vdd_below_3v0),
  .i_shared_io_pin(i_shared_io_pin), .i_mode_green(i_mode_green), .i_mode_idle(i_mode_idle),
  .i_mode_sleep(i_mode_sleep), .o_options_valid(o_options_valid), .o_warmup_clocks(o_warmup_clocks),
  .o_post_reset_green(o_post_reset_green), .o_lv_reset_enable(o_lv_reset_enable),
  .o_lv_level_3v0(o_lv_level_3v0), .o_lv_reset(o_lv_reset), .o_ext_reset_pin_en(o_ext_reset_pin_en),
  .o_ext_reset(o_ext_reset), .o_watchdog_enable(o_watchdog_enable), .o_filter_enable(o_filter_enable),
  .o_filter_min_width(o_filter_min_width), .o_code_protect(o_code_protect), .o_sub_osc_64k(o_sub_osc_64k),
  .o_osc_trim(o_osc_trim), .o_trim_period_pct(o_trim_period_pct));
`default_nettype wire

// file: sim/cod_option_decode_test.sv
/*
  self-checking bench for the option word decoder: power-on latching, decode,
  linked registers, low-voltage hold and pin reset.
  assumes a short low-voltage hold parameter of 4 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module cod_option_decode_test;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [14:0] w0 = 15'h7fff;
  logic [14:0] w1 = 15'h7fff;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [3:0]  cmp = 4'h0;
  logic [2:0]  mode = 3'h0;
  logic        pin = 1'b1;
  wire  [15:0] rdata;
  wire  [33:0] dec_seen;
  wire         lv_rst;
  wire         ext_rst;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          seed = 32'hd863_f1cf;
  logic [15:0] rq[$];

  cod_option_decode #(.LV_HOLD_CYCLES(4)) cod_option_decode_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_option_word0(w0), .i_option_word1(w1),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_vdd_below_2v7(cmp[0]), .i_vdd_above_2v9(cmp[1]), .i_vdd_below_3v0(cmp[2]), .i_vdd_above_3v2(cmp[3]),
    .i_shared_io_pin(pin), .i_mode_green(mode[0]), .i_mode_idle(mode[1]), .i_mode_sleep(mode[2]),
    .o_options_valid(dec_seen[33]), .o_warmup_clocks(dec_seen[32:27]), .o_post_reset_green(dec_seen[26]),
    .o_lv_reset_enable(dec_seen[25]), .o_lv_level_3v0(dec_seen[24]), .o_lv_reset(lv_rst),
    .o_ext_reset_pin_en(dec_seen[23]), .o_ext_reset(ext_rst), .o_watchdog_enable(dec_seen[22]),
    .o_filter_enable(dec_seen[21]), .o_filter_min_width(dec_seen[20:15]), .o_code_protect(dec_seen[14]),
    .o_sub_osc_64k(dec_seen[13]), .o_osc_trim(dec_seen[12:7]), .o_trim_period_pct(dec_seen[6:0]));

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  // ************************************************************
  // compare, report and expected decode
  // ************************************************************
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    n_compared++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [33:0] dec(input logic [14:0] a, input logic [14:0] b, input logic busy);
    logic [5:0] t;
    t = b[12:7];
    dec = {1'b1, a[13] ? 6'h08 : 6'h20, !a[10], !a[8], a[8:7] == 2'b00, !a[6], !a[5], a[3] & !busy,
           a[4] ? 6'h20 : 6'h08, a[2:0] == 3'b000, !b[13], t, t[5] ? {1'b0, t} - 7'h3f : 7'h20 - {1'b0, t}};
  endfunction

  // ************************************************************
  // drivers
  // ************************************************************
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd   <= 1'b0;
  endtask

  task automatic por(input logic [14:0] a, input logic [14:0] b);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    w0      <= a;
    w1      <= b;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic see(input logic [14:0] a, input logic [14:0] b);
    @(negedge i_clk);
    chk("decode", dec(a, b, |mode), dec_seen);
  endtask

  task automatic lv(input logic [3:0] v, input int n, input logic e);
    @(posedge i_clk);
    cmp <= v;
    repeat (n) @(posedge i_clk);
    cmp <= 4'h0;
    repeat (2) @(negedge i_clk);
    chk("lv reset", 34'(e), 34'(lv_rst));
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge i_clk)
  begin
    rd_d <= rd;
    if (rd_d)
      chk("rdata", 34'(rq.pop_front()), 34'(rdata));
  end

  initial
  begin
    #500000;
    error_cnt++;
    summarize();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    logic [14:0] a;
    logic [14:0] b;
    por(15'h7fff, 15'h7fff);
    see(15'h7fff, 15'h7fff);
    rd_reg(4'h0, 16'h7fff);
    rd_reg(4'h5, 16'h0005);
    rd_reg(4'hf, 16'h0000);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h0, 16'h0000);
    repeat (3) @(posedge i_clk);
    see(15'h7fff, 15'h7fff);
    rd_reg(4'h0, 16'h7fff);
    lv(4'h5, 8, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      a = 15'($random(seed)) | 15'h5a00;
      b = 15'($random(seed)) | 15'h4000;
      if (i[0])
        a[2:0] = 3'b000;
      por(a, b);
      mode <= 3'($random(seed));
      pin  <= i[1];
      repeat (3) @(posedge i_clk);
      see(a, b);
      chk("ext reset", 34'(!a[6] & !pin), 34'(ext_rst));
      @(posedge i_clk);
      w0 <= ~a | 15'h5a00;
      w1 <= ~b | 15'h4000;
      repeat (4) @(posedge i_clk);
      see(a, b);
    end
    @(posedge i_clk);
    mode <= 3'h0;
    pin  <= 1'b0;
    por(15'h3fff, 15'h7fff);
    rd_reg(4'h2, 16'h000f);
    rd_reg(4'h3, 16'h000f);
    rd_reg(4'h4, 16'h007f);
    rd_reg(4'h5, 16'h0001);
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h4, 16'h0020);
    repeat (3) @(posedge i_clk);
    see(15'h1a07, 15'h507f);
    chk("ext reset", 34'h1, 34'(ext_rst));
    rd_reg(4'h4, 16'h0020);
    lv(4'h1, 8, 1'b0);
    lv(4'h4, 3, 1'b0);
    lv(4'h4, 8, 1'b1);
    rd_reg(4'h5, 16'h0003);
    lv(4'h8, 2, 1'b0);
    por(15'h7eff, 15'h7fff);
    lv(4'h4, 8, 1'b0);
    lv(4'h1, 8, 1'b1);
    lv(4'h2, 2, 1'b0);
    see(15'h7eff, 15'h7fff);
    summarize();
  end
endmodule // cod_option_decode_test
`default_nettype wire
